/* hw/tw_pkg.sv */
// Shared constants and types of the two-wire configuration link.
// Assumes ref_clk at 100 MHz, which is also the crystal clock of the slave.
package tw_pkg;

	// Slave bus address: six fixed upper bits, strap gives bit 0
	localparam logic [5:0] ADDR_UPPER = 6'h26;

	// Configuration register file
	localparam int         REG_COUNT = 64;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] PLL_VIDEO_TUNING_OFS = 8'h1c;
	localparam logic [7:0] DC_RESTORE_CONTROL_OFS = 8'h23;

	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int DEGLITCH_CLKS  = 3;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int QUARTER_CLKS =
		(SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Host controller APB map
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TARGET = 8'h04;
	localparam logic [7:0] OFS_PTR    = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RDATA  = 8'h14;
	localparam int CTRL_GO   = 0;
	localparam int CTRL_READ = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam logic [6:0] TARGET_RESET = 7'h4c;

	// Slave byte-level states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_RACK = 5'h10
	} tw_state_type;

	// Meaning of the byte being received
	typedef enum logic [2:0] {
		PH_ADDR = 3'h1,
		PH_PTR  = 3'h2,
		PH_DATA = 3'h4
	} tw_phase_type;

	// Host bus symbols
	typedef enum logic [4:0] {
		SYM_START = 5'h01,
		SYM_STOP  = 5'h02,
		SYM_TX    = 5'h04,
		SYM_RX    = 5'h08,
		SYM_DONE  = 5'h10
	} tw_sym_type;

endpackage

/* hw/tw_bus_if.sv */
// Two-wire bus carrier joining the host end and the slave end.
// Open-drain lines resolve here; the slave end reads both wired-AND levels, the host end SDA only.
`timescale 1ns/1ps
`default_nettype none
interface tw_bus_if;
	logic scl;
	logic sda;
	logic sclHostOut;
	logic sclHostOe;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;

	// Wired-AND with pull-ups
	assign scl = ~(sclHostOe & ~sclHostOut);
	assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

	modport device (
		input  scl,
		input  sda,
		output sdaDevOut,
		output sdaDevOe
	);
	modport host (
		input  sda,
		output sclHostOut,
		output sclHostOe,
		output sdaHostOut,
		output sdaHostOe
	);
endinterface
`default_nettype wire

/* hw/tw_line_filter.sv */
// Pin synchroniser and deglitcher with edge pulses.
// Assumes raw comes from outside the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module tw_line_filter #(
	parameter int   STABLE = tw_pkg::DEGLITCH_CLKS,
	parameter logic INIT   = 1'b1
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic raw,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	localparam int CW = $clog2(STABLE + 1);

	logic          sync1_ff;
	logic          sync2_ff;
	logic [CW-1:0] cnt_ff;
	logic          change;

	assign change = (sync2_ff != level) && (cnt_ff == CW'(STABLE - 1));

	// Two-stage synchroniser
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= INIT;
			sync2_ff <= INIT;
		end else if (ce) begin
			sync1_ff <= raw;
			sync2_ff <= sync1_ff;
		end
	end

	// Level follows only after STABLE agreeing cycles
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			level  <= INIT;
			rise   <= 1'b0;
			fall   <= 1'b0;
		end else if (ce) begin
			rise <= change & sync2_ff;
			fall <= change & ~sync2_ff;
			if (sync2_ff == level || change) begin
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + CW'(1);
			end
			if (change) begin
				level <= sync2_ff;
			end
		end
	end
endmodule
`default_nettype wire

/* hw/tw_config_slave.sv */
// Two-wire configuration slave with its register file.
// Assumes the bus pins arrive through tw_bus_if; ref_clk is the crystal.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tw_config_slave #(
	parameter int REG_COUNT = tw_pkg::REG_COUNT
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   addrStrap,
	input  wire logic                   extReset_n,
	tw_bus_if.device                    bus,
	output logic [8*REG_COUNT-1:0]      cfgData,
	output logic                        selected
);
	localparam int IW = $clog2(REG_COUNT);

	tw_pkg::tw_state_type state_ff;
	tw_pkg::tw_phase_type phase_ff;
	logic       sclLvl;
	logic       sclRise;
	logic       sclFall;
	logic       sdaLvl;
	logic       sdaRise;
	logic       sdaFall;
	logic       strapLvl;
	logic       extRstLvl;
	logic       softRst;
	logic       startSeen;
	logic       stopSeen;
	logic [6:0] ownAddr;
	logic [3:0] bitCnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] txShift_ff;
	logic [7:0] ptr_ff;
	logic       readMode_ff;
	logic       hostAck_ff;
	logic       sdaOe_ff;
	logic       byteDone;
	logic       wrEn;
	logic       ptrLoad;
	logic       loadTx;
	logic [7:0] rdByte;
	logic [7:0] cfg_ff [REG_COUNT];

	// Bus lines, strap and reset pin, each synchronised and deglitched
	tw_line_filter u_scl (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.raw     (bus.scl),
		.level   (sclLvl),
		.rise    (sclRise),
		.fall    (sclFall)
	);
	tw_line_filter u_sda (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.raw     (bus.sda),
		.level   (sdaLvl),
		.rise    (sdaRise),
		.fall    (sdaFall)
	);
	tw_line_filter u_strap (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.raw     (addrStrap),
		.level   (strapLvl),
		.rise    (),
		.fall    ()
	);
	tw_line_filter u_rstpin (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.raw     (extReset_n),
		.level   (extRstLvl),
		.rise    (),
		.fall    ()
	);

	// Bus conditions and byte strobes
	assign softRst   = ~extRstLvl;
	assign ownAddr   = {tw_pkg::ADDR_UPPER, strapLvl};
	assign startSeen = sdaFall & sclLvl;
	assign stopSeen  = sdaRise & sclLvl;
	assign byteDone  = (state_ff == tw_pkg::ST_RX) && sclFall
		&& (bitCnt_ff == 4'h8);
	assign wrEn    = byteDone && (phase_ff == tw_pkg::PH_DATA);
	assign ptrLoad = byteDone && (phase_ff == tw_pkg::PH_PTR);
	assign loadTx  = sclFall && (((state_ff == tw_pkg::ST_ACK)
		&& readMode_ff) || ((state_ff == tw_pkg::ST_RACK) && hostAck_ff));
	assign rdByte  = (ptr_ff < 8'(REG_COUNT)) ? cfg_ff[ptr_ff[IW-1:0]]
		: 8'h00;

	// Open-drain data pin, never a clock output
	assign bus.sdaDevOut = 1'b0;
	assign bus.sdaDevOe  = sdaOe_ff;
	assign selected      = ~state_ff[0];

	// Byte-level protocol engine
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= tw_pkg::ST_IDLE;
			phase_ff    <= tw_pkg::PH_ADDR;
			bitCnt_ff   <= 4'h0;
			shift_ff    <= 8'h00;
			txShift_ff  <= 8'h00;
			readMode_ff <= 1'b0;
			hostAck_ff  <= 1'b0;
			sdaOe_ff    <= 1'b0;
		end else if (ce) begin
			if (softRst) begin
				state_ff <= tw_pkg::ST_IDLE;
				sdaOe_ff <= 1'b0;
			end else if (startSeen) begin
				state_ff  <= tw_pkg::ST_RX;
				phase_ff  <= tw_pkg::PH_ADDR;
				bitCnt_ff <= 4'h0;
				sdaOe_ff  <= 1'b0;
			end else if (stopSeen) begin
				state_ff <= tw_pkg::ST_IDLE;
				sdaOe_ff <= 1'b0;
			end else begin
				unique case (state_ff)
				tw_pkg::ST_IDLE: begin
					sdaOe_ff <= 1'b0;
				end
				tw_pkg::ST_RX: begin
					if (sclRise) begin
						// Capture on delayed rising edge
						shift_ff  <= {shift_ff[6:0], sdaLvl};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end else if (byteDone) begin
						unique case (phase_ff)
						tw_pkg::PH_ADDR: begin
							if (shift_ff[7:1] == ownAddr) begin
								sdaOe_ff    <= 1'b1;
								readMode_ff <= shift_ff[0];
								state_ff    <= tw_pkg::ST_ACK;
							end else begin
								state_ff <= tw_pkg::ST_IDLE;
							end
						end
						tw_pkg::PH_PTR, tw_pkg::PH_DATA: begin
							sdaOe_ff <= 1'b1;
							state_ff <= tw_pkg::ST_ACK;
						end
						endcase
					end
				end
				tw_pkg::ST_ACK: begin
					if (sclFall) begin
						bitCnt_ff <= 4'h0;
						if (readMode_ff) begin
							// First read bit after delayed fall
							state_ff   <= tw_pkg::ST_TX;
							txShift_ff <= rdByte;
							sdaOe_ff   <= ~rdByte[7];
						end else begin
							state_ff <= tw_pkg::ST_RX;
							sdaOe_ff <= 1'b0;
							phase_ff <= (phase_ff == tw_pkg::PH_ADDR)
								? tw_pkg::PH_PTR : tw_pkg::PH_DATA;
						end
					end
				end
				tw_pkg::ST_TX: begin
					if (sclFall) begin
						if (bitCnt_ff == 4'h7) begin
							sdaOe_ff <= 1'b0;
							state_ff <= tw_pkg::ST_RACK;
						end else begin
							txShift_ff <= {txShift_ff[6:0], 1'b0};
							sdaOe_ff   <= ~txShift_ff[6];
							bitCnt_ff  <= bitCnt_ff + 4'h1;
						end
					end
				end
				tw_pkg::ST_RACK: begin
					if (sclRise) begin
						hostAck_ff <= ~sdaLvl;
					end else if (sclFall) begin
						bitCnt_ff <= 4'h0;
						if (hostAck_ff) begin
							state_ff   <= tw_pkg::ST_TX;
							txShift_ff <= rdByte;
							sdaOe_ff   <= ~rdByte[7];
						end else begin
							state_ff <= tw_pkg::ST_IDLE;
							sdaOe_ff <= 1'b0;
						end
					end
				end
				endcase
			end
		end
	end

	// Register pointer: load, then step after each byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= 8'h00;
		end else if (ce) begin
			if (softRst) begin
				ptr_ff <= 8'h00;
			end else if (ptrLoad) begin
				ptr_ff <= shift_ff;
			end else if (wrEn) begin
				ptr_ff <= ptr_ff + 8'h01;
			end else if (loadTx) begin
				ptr_ff <= ptr_ff + 8'h01;
			end
		end
	end

	// Register file, one word per entry
	genvar g;
	generate
		for (g = 0; g < REG_COUNT; g++) begin : gen_reg
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					cfg_ff[g] <= tw_pkg::CFG_RESET;
				end else if (ce) begin
					if (softRst) begin
						cfg_ff[g] <= tw_pkg::CFG_RESET;
					end else if (wrEn && ptr_ff == 8'(g)) begin
						cfg_ff[g] <= shift_ff;
					end
				end
			end
			assign cfgData[8*g +: 8] = cfg_ff[g];
		end
	endgenerate
endmodule
`default_nettype wire

/* hw/tw_bus_host.sv */
// Two-wire bus master controlled over APB.
// Assumes one slave per transaction; no clock stretching on SCL.
`timescale 1ns/1ps
`default_nettype none
module tw_bus_host #(
	parameter int QUARTER = tw_pkg::QUARTER_CLKS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	tw_bus_if.host           bus
);
	tw_pkg::tw_sym_type kind;
	logic [7:0]  symByte;
	logic        sclLvl;
	logic        sdaLvl;
	logic        sdaSync1_ff;
	logic        sdaIn_ff;
	logic [11:0] cnt_ff;
	logic        tick;
	logic [2:0]  step_ff;
	logic [3:0]  bit_ff;
	logic [1:0]  qtr_ff;
	logic        busy_ff;
	logic        nack_ff;
	logic        readOp_ff;
	logic [6:0]  target_ff;
	logic [7:0]  ptrReg_ff;
	logic [7:0]  wdata_ff;
	logic [7:0]  rxShift_ff;
	logic [7:0]  rdata_ff;
	logic        sclOe_ff;
	logic        sdaOe_ff;
	logic        wrAcc;
	logic        mapped;
	logic        go;
	logic        sample;
	logic        symEnd;

	// APB decode; answer one cycle into the access phase
	assign wrAcc  = psel & penable & pready & pwrite;
	assign go     = wrAcc && paddr == tw_pkg::OFS_CTRL
		&& pwdata[tw_pkg::CTRL_GO] && !busy_ff;
	assign mapped = paddr == tw_pkg::OFS_CTRL || paddr == tw_pkg::OFS_TARGET
		|| paddr == tw_pkg::OFS_PTR || paddr == tw_pkg::OFS_WDATA
		|| paddr == tw_pkg::OFS_STATUS || paddr == tw_pkg::OFS_RDATA;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			unique case (paddr)
			tw_pkg::OFS_CTRL:   prdata <= {30'h0, readOp_ff, 1'b0};
			tw_pkg::OFS_TARGET: prdata <= {25'h0, target_ff};
			tw_pkg::OFS_PTR:    prdata <= {24'h0, ptrReg_ff};
			tw_pkg::OFS_WDATA:  prdata <= {24'h0, wdata_ff};
			tw_pkg::OFS_STATUS: prdata <= {30'h0, nack_ff, busy_ff};
			tw_pkg::OFS_RDATA:  prdata <= {24'h0, rdata_ff};
			default:            prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_ff <= tw_pkg::TARGET_RESET;
			ptrReg_ff <= 8'h00;
			wdata_ff  <= 8'h00;
			readOp_ff <= 1'b0;
		end else if (ce && wrAcc && !busy_ff) begin
			if (paddr == tw_pkg::OFS_TARGET) target_ff <= pwdata[6:0];
			if (paddr == tw_pkg::OFS_PTR) ptrReg_ff <= pwdata[7:0];
			if (paddr == tw_pkg::OFS_WDATA) wdata_ff <= pwdata[7:0];
			if (go) readOp_ff <= pwdata[tw_pkg::CTRL_READ];
		end
	end

	// Symbol sequence; reads set pointer then restart
	always_comb begin
		kind    = tw_pkg::SYM_DONE;
		symByte = 8'hff;
		unique case (step_ff)
		3'h0: kind = tw_pkg::SYM_START;
		3'h1: begin
			kind    = tw_pkg::SYM_TX;
			symByte = {target_ff, 1'b0};
		end
		3'h2: begin
			kind    = tw_pkg::SYM_TX;
			symByte = ptrReg_ff;
		end
		3'h3: begin
			kind    = readOp_ff ? tw_pkg::SYM_START : tw_pkg::SYM_TX;
			symByte = wdata_ff;
		end
		3'h4: begin
			kind    = readOp_ff ? tw_pkg::SYM_TX : tw_pkg::SYM_STOP;
			symByte = {target_ff, 1'b1};
		end
		3'h5: kind = readOp_ff ? tw_pkg::SYM_RX : tw_pkg::SYM_DONE;
		3'h6: kind = readOp_ff ? tw_pkg::SYM_STOP : tw_pkg::SYM_DONE;
		3'h7: kind = tw_pkg::SYM_DONE;
		endcase
	end

	// Line levels per quarter; SDA moves with SCL high only in START and STOP
	always_comb begin
		sclLvl = 1'b1;
		sdaLvl = 1'b1;
		unique case (kind)
		tw_pkg::SYM_START: begin
			sclLvl = qtr_ff == 2'h1 || qtr_ff == 2'h2;
			sdaLvl = qtr_ff < 2'h2;
		end
		tw_pkg::SYM_STOP: begin
			sclLvl = qtr_ff != 2'h0;
			sdaLvl = qtr_ff >= 2'h2;
		end
		tw_pkg::SYM_TX: begin
			sclLvl = qtr_ff == 2'h1 || qtr_ff == 2'h2;
			sdaLvl = bit_ff[3] | symByte[3'h7 - bit_ff[2:0]];
		end
		tw_pkg::SYM_RX: begin
			sclLvl = qtr_ff == 2'h1 || qtr_ff == 2'h2;
			sdaLvl = 1'b1;
		end
		tw_pkg::SYM_DONE: begin
			sclLvl = 1'b1;
			sdaLvl = 1'b1;
		end
		endcase
	end

	assign tick   = cnt_ff == 12'(QUARTER - 1);
	assign sample = busy_ff && tick && qtr_ff == 2'h2;
	assign symEnd = busy_ff && tick && qtr_ff == 2'h3;

	// Quarter-bit timer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 12'h000;
		end else if (ce) begin
			cnt_ff <= (tick || !busy_ff) ? 12'h000 : cnt_ff + 12'h001;
		end
	end

	// SDA pin synchroniser
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdaSync1_ff <= 1'b1;
			sdaIn_ff    <= 1'b1;
		end else if (ce) begin
			sdaSync1_ff <= bus.sda;
			sdaIn_ff    <= sdaSync1_ff;
		end
	end

	// Sequencer, sampling and status
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_ff    <= 3'h0;
			bit_ff     <= 4'h0;
			qtr_ff     <= 2'h0;
			busy_ff    <= 1'b0;
			nack_ff    <= 1'b0;
			rxShift_ff <= 8'h00;
			rdata_ff   <= 8'h00;
		end else if (ce) begin
			if (go) begin
				busy_ff <= 1'b1;
				nack_ff <= 1'b0;
				step_ff <= 3'h0;
				bit_ff  <= 4'h0;
				qtr_ff  <= 2'h0;
			end else if (busy_ff && kind == tw_pkg::SYM_DONE) begin
				busy_ff <= 1'b0;
			end else if (tick && busy_ff) begin
				qtr_ff <= qtr_ff + 2'h1;
				if (sample && kind == tw_pkg::SYM_TX && bit_ff[3]) begin
					nack_ff <= nack_ff | sdaIn_ff;
				end
				if (sample && kind == tw_pkg::SYM_RX && !bit_ff[3]) begin
					rxShift_ff <= {rxShift_ff[6:0], sdaIn_ff};
				end
				if (symEnd) begin
					if ((kind == tw_pkg::SYM_TX || kind == tw_pkg::SYM_RX)
						&& !bit_ff[3]) begin
						bit_ff <= bit_ff + 4'h1;
					end else begin
						bit_ff  <= 4'h0;
						step_ff <= step_ff + 3'h1;
						if (kind == tw_pkg::SYM_RX) rdata_ff <= rxShift_ff;
					end
				end
			end
		end
	end

	// Registered open-drain drive of both lines
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclOe_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
		end else if (ce) begin
			sclOe_ff <= busy_ff & ~sclLvl;
			sdaOe_ff <= busy_ff & ~sdaLvl;
		end
	end

	assign bus.sclHostOut = 1'b0;
	assign bus.sclHostOe  = sclOe_ff;
	assign bus.sdaHostOut = 1'b0;
	assign bus.sdaHostOe  = sdaOe_ff;
endmodule
`default_nettype wire

/* verif/tw_link_monitor.sv */
// Checker on the two-wire lines between host end and slave end.
// Assumes it sits beside tw_bus_if and sees the slave strap pin.
`timescale 1ns/1ps
`default_nettype none
module tw_link_monitor (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic addrStrap,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sdaDevOut,
	input  wire logic sdaDevOe
);
	logic       sclQ_ff, sdaQ_ff, seen_ff, wrSel_ff, rdSel_ff;
	logic [5:0] riseCnt_ff;
	logic [7:0] addrSh_ff;
	logic       startEv, stopEv, sclRise, sclFall, addrHit;

	// Line events seen at the pins
	assign startEv = sclQ_ff & scl & sdaQ_ff & ~sda;
	assign stopEv  = sclQ_ff & scl & ~sdaQ_ff & sda;
	assign sclRise = scl & ~sclQ_ff;
	assign sclFall = ~scl & sclQ_ff;
	assign addrHit = addrSh_ff[7:1] == {tw_pkg::ADDR_UPPER, addrStrap};

	// Line history and first START
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclQ_ff <= 1'b1;
			sdaQ_ff <= 1'b1;
			seen_ff <= 1'b0;
		end else begin
			sclQ_ff <= scl;
			sdaQ_ff <= sda;
			seen_ff <= seen_ff | startEv;
		end
	end

	// Clock count, address capture and selection since START
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			riseCnt_ff <= 6'h00;
			addrSh_ff  <= 8'h00;
			wrSel_ff   <= 1'b0;
			rdSel_ff   <= 1'b0;
		end else if (startEv || stopEv) begin
			riseCnt_ff <= 6'h00;
			wrSel_ff   <= 1'b0;
			rdSel_ff   <= 1'b0;
		end else begin
			if (sclRise && riseCnt_ff != 6'h3f)
				riseCnt_ff <= riseCnt_ff + 6'h01;
			if (sclRise && riseCnt_ff < 6'h08)
				addrSh_ff <= {addrSh_ff[6:0], sda};
			if (sclFall && riseCnt_ff == 6'h08) begin
				wrSel_ff <= addrHit & ~addrSh_ff[0];
				rdSel_ff <= addrHit & addrSh_ff[0];
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_open_drain; sdaDevOut == 1'b0; endproperty
	property p_quiet_idle; !seen_ff |-> !sdaDevOe; endproperty
	property p_change_low;
		$changed(sdaDevOe) |->
			!scl && !$past(scl) && !$past(scl, 2) && !$past(scl, 3);
	endproperty
	property p_addr_ack;
		sclFall && riseCnt_ff == 6'h08 && addrHit |-> ##[1:12] sdaDevOe;
	endproperty
	property p_addr_miss;
		sclFall && riseCnt_ff == 6'h08 && !addrHit |=> !sdaDevOe [*8];
	endproperty
	property p_no_early; $rose(sdaDevOe) |-> riseCnt_ff >= 6'h08; endproperty
	property p_wr_ack;
		sclFall && wrSel_ff && (riseCnt_ff == 6'h11 || riseCnt_ff == 6'h1a)
			|-> ##[1:12] sdaDevOe;
	endproperty
	property p_stop_release; stopEv |=> !sdaDevOe [*8]; endproperty
	property p_nack_release;
		sclFall && rdSel_ff && riseCnt_ff == 6'h12 && sdaQ_ff
			|=> !sdaDevOe [*8];
	endproperty
	// SDA may move with SCL high only on the first clock of a symbol
	property p_line_stable;
		sclQ_ff && scl && sda != sdaQ_ff |-> riseCnt_ff % 6'h09 == 6'h01;
	endproperty

	a_open_drain: assert property (p_open_drain)
		else $error("slave drives sda high");
	a_quiet_idle: assert property (p_quiet_idle)
		else $error("slave drives before any start");
	a_change_low: assert property (p_change_low)
		else $error("slave sda changes too near scl high");
	a_addr_ack: assert property (p_addr_ack)
		else $error("own address not acknowledged");
	a_addr_miss: assert property (p_addr_miss)
		else $error("foreign address acknowledged");
	a_no_early: assert property (p_no_early)
		else $error("slave drives inside address byte");
	a_wr_ack: assert property (p_wr_ack)
		else $error("written byte not acknowledged");
	a_stop_release: assert property (p_stop_release)
		else $error("slave drives after stop");
	a_nack_release: assert property (p_nack_release)
		else $error("slave drives after missing ack");
	a_line_stable: assert property (p_line_stable)
		else $error("sda moves with scl high inside a byte");

	// Main scenarios reached
	c_write: cover property (sclFall && wrSel_ff && riseCnt_ff == 6'h1a);
	c_read: cover property (rdSel_ff && riseCnt_ff == 6'h12);
	c_stop: cover property (stopEv);
endmodule
`default_nettype wire

/* verif/tw_config_slave_tb.sv */
// Bench: APB drives the host end, which talks to the slave end.
// Assumes QUARTER of 10 cycles, so one bus bit is 40 ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module tw_config_slave_tb;
	typedef struct packed {
		logic       rd;
		logic [6:0] tgt;
		logic [7:0] ptr;
		logic [7:0] wdat;
		logic [7:0] exp;
		logic       nack;
	} tw_row_type;

	logic                           ref_clk, rst_n, ce, addrStrap, extReset_n;
	logic                           psel, penable, pwrite, pready, pslverr;
	logic                           selected, errv;
	logic [7:0]                     paddr;
	logic [31:0]                    pwdata, prdata, rdv;
	logic [8*tw_pkg::REG_COUNT-1:0] cfgData;
	int                             nErrors, nChecks, cycles;
	tw_row_type                     rows [10];

	tw_bus_if tw_bus_if_inst ();
	tw_config_slave tw_config_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.ce(ce), .addrStrap(addrStrap), .extReset_n(extReset_n),
		.bus(tw_bus_if_inst.device), .cfgData(cfgData), .selected(selected));
	tw_bus_host #(.QUARTER(10)) tw_bus_host_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus(tw_bus_if_inst.host));
	tw_link_monitor tw_link_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.addrStrap(addrStrap), .scl(tw_bus_if_inst.scl),
		.sda(tw_bus_if_inst.sda), .sdaDevOut(tw_bus_if_inst.sdaDevOut),
		.sdaDevOe(tw_bus_if_inst.sdaDevOe));

	// Clock and hang guard
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			nErrors++;
			finalReport();
		end
	end

	task automatic finalReport();
		if (nErrors == 0 && nChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			nErrors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Full bus operation through the host registers, then checks
	task automatic op(input tw_row_type r);
		apb(1'b1, tw_pkg::OFS_TARGET, {25'h0, r.tgt});
		apb(1'b1, tw_pkg::OFS_PTR, {24'h0, r.ptr});
		apb(1'b1, tw_pkg::OFS_WDATA, {24'h0, r.wdat});
		apb(1'b1, tw_pkg::OFS_CTRL, {30'h0, r.rd, 1'b1});
		// Ignored while busy, so the address sent stays put
		apb(1'b1, tw_pkg::OFS_TARGET, 32'h0);
		do apb(1'b0, tw_pkg::OFS_STATUS, 32'h0);
		while (rdv[tw_pkg::STAT_BUSY] !== 1'b0);
		chk("nack", {31'h0, r.nack}, {31'h0, rdv[tw_pkg::STAT_NACK]});
		if (r.rd) begin
			apb(1'b0, tw_pkg::OFS_RDATA, 32'h0);
			chk("rdata", {24'h0, r.exp}, rdv);
		end else if (r.ptr < 8'h40)
			chk("cfg", {24'h0, r.exp}, {24'h0, cfgData[8*r.ptr +: 8]});
		// Pointer steps once past the byte moved
		if (!r.nack)
			chk("ptr step", {24'h0, r.ptr + 8'h01},
				{24'h0, tw_config_slave_inst.ptr_ff});
		chk("selected", 32'h0, {31'h0, selected});
		apb(1'b0, tw_pkg::OFS_TARGET, 32'h0);
		chk("busy write", {25'h0, r.tgt}, rdv);
	endtask

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		addrStrap = 1'b0;
		extReset_n = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		// Read, target, pointer, write data, expected, nack
		rows = '{
			{1'b0, 7'h4c, 8'h1c, 8'h49, 8'h49, 1'b0},
			{1'b0, 7'h4c, 8'h23, 8'h78, 8'h78, 1'b0},
			{1'b1, 7'h4c, 8'h1c, 8'h00, 8'h49, 1'b0},
			{1'b1, 7'h4c, 8'h23, 8'h00, 8'h78, 1'b0},
			{1'b0, 7'h4d, 8'h05, 8'ha5, 8'h00, 1'b1},
			{1'b1, 7'h4c, 8'h05, 8'h00, 8'h00, 1'b0},
			{1'b0, 7'h4c, 8'h3f, 8'h5a, 8'h5a, 1'b0},
			{1'b1, 7'h4c, 8'h3f, 8'h00, 8'h5a, 1'b0},
			{1'b0, 7'h4c, 8'h40, 8'h77, 8'h00, 1'b0},
			{1'b1, 7'h4c, 8'h40, 8'h00, 8'h00, 1'b0}};
		repeat (8) @(posedge ref_clk);
		chk("cfg at reset", 32'h0, {31'h0, |cfgData});
		chk("sel at reset", 32'h0, {31'h0, selected});
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		apb(1'b0, tw_pkg::OFS_TARGET, 32'h0);
		chk("target reset", {25'h0, tw_pkg::TARGET_RESET}, rdv);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
		foreach (rows[i])
			op(rows[i]);
		// Strap high moves the slave to the odd address
		addrStrap <= 1'b1;
		repeat (10) @(posedge ref_clk);
		op({1'b0, 7'h4d, 8'h10, 8'h3c, 8'h3c, 1'b0});
		op({1'b0, 7'h4c, 8'h11, 8'h3c, 8'h00, 1'b1});
		addrStrap <= 1'b0;
		// Reset pin is frozen with ce low, then clears every register
		ce <= 1'b0;
		extReset_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("cfg frozen", 32'h1, {31'h0, |cfgData});
		ce <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("cfg after pin", 32'h0, {31'h0, |cfgData});
		extReset_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		op({1'b1, 7'h4c, 8'h1c, 8'h00, 8'h00, 1'b0});
		finalReport();
	end
endmodule
`default_nettype wire
